// ===== rtl/bnu_branch_unit.sv
// Decode and execute unit for the branch-if-negative family
// Operation
// [RULE_01] Target is delay-slot address plus scaled offset
// [RULE_02] Taken exactly when source sign bit set
// [RULE_03] Likely forms nullify slot when not taken
// [RULE_04] Linking forms write register 31 with pc+8
// [RULE_05] Source must not be register 31 when linking; the unit does not check this and links anyway
// [RULE_06] Slot exception resumes by re-executing the branch
// [RULE_07] No control-transfer instruction in the delay slot
// [RULE_08] Decode major opcode, source, sub-opcode, immediate
// [RULE_09] Redirect lands in the cycle after the branch
// [RULE_10] Earliest level treats likely forms as reserved
// [RULE_11] Software should avoid likely forms
// [RULE_12] Likely forms are predicted taken statically
// [RULE_13] Software keeps targets within 128 KBytes
// [RULE_14] Full-width signed test, no own exceptions
// [RULE_15] Non-likely false: run slot, fall through
`timescale 1ns/10ps
`default_nettype none
module bnu_branch_unit
  import bnu_pkg::*;
#(
  parameter int unsigned REG_W = 32,
  parameter int unsigned PC_W = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic early_level_i,
  input wire logic instr_valid_i,
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic [PC_W-1:0] instr_pc_i,
  input wire logic [REG_W-1:0] src_data_i,
  input wire logic slot_exc_i,
  output logic [4:0] src_idx_o,
  output logic branch_hit_o,
  output logic reserved_exc_o,
  output logic predict_taken_o,
  output logic slot_nullify_o,
  output logic mispredict_o,
  output logic redirect_o,
  output logic [PC_W-1:0] target_o,
  output logic link_we_o,
  output logic [4:0] link_idx_o,
  output logic [REG_W-1:0] link_data_o,
  output logic resume_o,
  output logic [PC_W-1:0] resume_pc_o,
  output logic busy_o
);
  // Decode results for the instruction on the port
  logic dec_hit;
  logic dec_likely;
  logic dec_link;
  logic dec_reserved;
  logic [IMM_W-1:0] dec_imm;
  logic [OFS_W-1:0] ofs_short;
  logic [PC_W-1:0] ofs_ext;
  logic cond_now;
  logic take_branch;
  logic in_slot;
  logic slot_seen;
  logic slot_squash;
  logic slot_trap;

  // Registered state, each with its next value
  bnu_state_e state_r;
  bnu_state_e state_nxt;
  logic cond_r;
  logic cond_nxt;
  logic likely_r;
  logic likely_nxt;
  logic [PC_W-1:0] target_r;
  logic [PC_W-1:0] target_nxt;
  logic [PC_W-1:0] branch_pc_r;
  logic [PC_W-1:0] branch_pc_nxt;
  logic link_we_r;
  logic link_we_nxt;
  logic [REG_W-1:0] link_data_r;
  logic [REG_W-1:0] link_data_nxt;
  logic resume_r;
  logic resume_nxt;

  bnu_decode u_decode (
    .instr_i(instr_i),
    .early_level_i(early_level_i),
    .hit_o(dec_hit),
    .likely_o(dec_likely),
    .link_o(dec_link),
    .reserved_o(dec_reserved),
    .src_idx_o(src_idx_o),
    .imm_o(dec_imm)
  );

  always_comb begin
    in_slot = (state_r == BNU_ST_SLOT);
    // A branch sitting in a delay slot is not started again
    take_branch = instr_valid_i && dec_hit && !in_slot; // RULE_07
    ofs_short = {dec_imm, {OFS_SHIFT{1'b0}}}; // RULE_01
    ofs_ext = PC_W'($signed(ofs_short)); // RULE_01
    cond_now = $signed(src_data_i) < $signed({REG_W{1'b0}}); // RULE_14 RULE_02
  end

  // Combinational handshakes toward fetch and pipeline
  always_comb begin
    branch_hit_o = take_branch;
    reserved_exc_o = instr_valid_i && dec_reserved && !in_slot; // RULE_10
    predict_taken_o = take_branch && dec_likely; // RULE_12
    // Slot outcome; an exception in the slot cancels the redirect
    redirect_o = slot_seen && cond_r && !slot_exc_i; // RULE_09 RULE_02
    slot_nullify_o = slot_squash; // RULE_03 RULE_15
    mispredict_o = slot_nullify_o; // RULE_12
    busy_o = in_slot;
  end

  // Slot cycle bookkeeping shared by the groups below
  always_comb begin
    slot_seen = in_slot && instr_valid_i;
    // A nullified slot instruction leaves no trace, its fault included
    slot_squash = slot_seen && likely_r && !cond_r; // RULE_03
    slot_trap = slot_seen && slot_exc_i && !slot_squash; // RULE_03 RULE_06
  end

  // Control group: idle or waiting for the delay slot
  always_comb begin
    state_nxt = state_r;
    cond_nxt = cond_r;
    likely_nxt = likely_r;
    unique case (state_r)
      BNU_ST_IDLE: begin
        if (take_branch) begin
          state_nxt = BNU_ST_SLOT;
          // Offset and test both settle in the branch's own cycle
          cond_nxt = cond_now; // RULE_09
          likely_nxt = dec_likely;
        end
      end
      BNU_ST_SLOT: begin
        // Not-taken plain forms simply fall through after the slot
        if (slot_seen) begin // RULE_15
          state_nxt = BNU_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= BNU_ST_IDLE;
      cond_r <= 1'b0;
      likely_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cond_r <= cond_nxt;
      likely_r <= likely_nxt;
    end
  end

  // Address group: target and the branch's own address
  always_comb begin
    target_nxt = target_r;
    branch_pc_nxt = branch_pc_r;
    if (take_branch) begin
      target_nxt = instr_pc_i + PC_W'(INSTR_STEP) + ofs_ext; // RULE_01
      branch_pc_nxt = instr_pc_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      target_r <= '0;
      branch_pc_r <= '0;
    end else begin
      target_r <= target_nxt;
      branch_pc_r <= branch_pc_nxt;
    end
  end

  // Link group: one write pulse the cycle after the branch
  always_comb begin
    link_we_nxt = 1'b0;
    link_data_nxt = link_data_r;
    if (take_branch) begin
      // Link written taken or not; a source of 31 is the caller's fault
      link_we_nxt = dec_link; // RULE_04 RULE_05
      link_data_nxt = REG_W'(instr_pc_i + LINK_STEP); // RULE_04
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_we_r <= 1'b0;
      link_data_r <= '0;
    end else begin
      link_we_r <= link_we_nxt;
      link_data_r <= link_data_nxt;
    end
  end

  // Resume group: one pulse after a faulting slot instruction
  always_comb begin
    resume_nxt = slot_trap; // RULE_06
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      resume_r <= 1'b0;
    end else begin
      resume_r <= resume_nxt;
    end
  end

  always_comb begin
    target_o = target_r;
    link_we_o = link_we_r;
    link_idx_o = LINK_REG_IDX; // RULE_04
    link_data_o = link_data_r;
    resume_o = resume_r;
    // Handler restarts at the branch, which relinks and retests
    resume_pc_o = branch_pc_r; // RULE_06
  end
endmodule : bnu_branch_unit
`default_nettype wire

// ===== rtl/bnu_pkg.sv
// Constants shared by the negative-test branch unit
package bnu_pkg;
  localparam int unsigned INSTR_W = 32;
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned SRC_HI = 25;
  localparam int unsigned SRC_LO = 21;
  localparam int unsigned SUB_HI = 20;
  localparam int unsigned SUB_LO = 16;
  localparam int unsigned IMM_HI = 15;
  localparam int unsigned IMM_LO = 0;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned OFS_SHIFT = 2;
  localparam int unsigned OFS_W = 18;
  localparam logic [5:0] OPC_REG_IMM = 6'h01;
  localparam logic [4:0] SUB_NEG = 5'h00;
  localparam logic [4:0] SUB_NEG_LINK = 5'h10;
  localparam logic [4:0] SUB_NEG_LIKELY = 5'h02;
  localparam logic [4:0] SUB_NEG_LINK_LIKELY = 5'h12;
  localparam logic [4:0] LINK_REG_IDX = 5'h1f;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;
  localparam logic [31:0] LINK_STEP = 32'h0000_0008;
  typedef enum logic [1:0] {
    BNU_ST_IDLE = 2'b01,
    BNU_ST_SLOT = 2'b10
  } bnu_state_e;
endpackage : bnu_pkg

// ===== rtl/bnu_decode.sv
// Field decoder for the register-immediate negative-test branches
`timescale 1ns/10ps
`default_nettype none
module bnu_decode
  import bnu_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_i,
  input wire logic early_level_i,
  output logic hit_o,
  output logic likely_o,
  output logic link_o,
  output logic reserved_o,
  output logic [4:0] src_idx_o,
  output logic [IMM_W-1:0] imm_o
);
  logic [5:0] opc;
  logic [4:0] sub;
  logic known;

  always_comb begin
    opc = instr_i[OPC_HI:OPC_LO]; // RULE_08
    sub = instr_i[SUB_HI:SUB_LO];
    src_idx_o = instr_i[SRC_HI:SRC_LO];
    imm_o = instr_i[IMM_HI:IMM_LO];
    known = 1'b0;
    likely_o = 1'b0;
    link_o = 1'b0;
    if (opc == OPC_REG_IMM) begin
      unique case (sub)
        SUB_NEG: begin
          known = 1'b1;
        end
        SUB_NEG_LINK: begin
          known = 1'b1;
          link_o = 1'b1;
        end
        SUB_NEG_LIKELY: begin // RULE_08
          known = 1'b1;
          likely_o = 1'b1;
        end
        SUB_NEG_LINK_LIKELY: begin // RULE_08
          known = 1'b1;
          likely_o = 1'b1;
          link_o = 1'b1;
        end
        default: begin
          known = 1'b0;
        end
      endcase
    end
    // Earliest level has no likely forms at all
    reserved_o = known && likely_o && early_level_i; // RULE_10
    hit_o = known && !reserved_o;
  end
endmodule : bnu_decode
`default_nettype wire

// ===== bench/bnu_regfile.sv
// Register file stand-in facing the branch unit
`timescale 1ns/10ps
`default_nettype none
module bnu_regfile (
  input wire logic clk_i,
  input wire logic [4:0] rd_idx_i,
  output logic [31:0] rd_data_o,
  input wire logic we_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [31:0] wr_data_i
);
  logic [31:0] regs [32];
  // Combinational read: the unit tests the value in its issue cycle
  assign rd_data_o = regs[rd_idx_i];
  always @(posedge clk_i) begin
    if (we_i) begin
      regs[wr_idx_i] <= wr_data_i;
    end
  end
endmodule : bnu_regfile
`default_nettype wire

// ===== bench/bnu_properties.sv
// Port assertions for the branch unit
`timescale 1ns/10ps
`default_nettype none
module bnu_properties (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic early_level_i,
  input wire logic instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] instr_pc_i,
  input wire logic slot_exc_i,
  input wire logic branch_hit_o,
  input wire logic predict_taken_o,
  input wire logic reserved_exc_o,
  input wire logic slot_nullify_o,
  input wire logic redirect_o,
  input wire logic [31:0] target_o,
  input wire logic link_we_o,
  input wire logic [31:0] link_data_o,
  input wire logic resume_o,
  input wire logic busy_o
);
  logic [31:0] exp_tgt;
  logic dec;
  assign exp_tgt = instr_pc_i + 32'h4 + {{14{instr_i[15]}}, instr_i[15:0], 2'b00};
  assign dec = instr_valid_i && !busy_o && instr_i[31:26] == 6'h01;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_target_calc: assert property (branch_hit_o |=> target_o == $past(exp_tgt))
    else $error("target wrong");
  a_link_write: assert property (branch_hit_o && instr_i[20] |=>
    link_we_o && link_data_o == $past(instr_pc_i) + 32'h8) else $error("link wrong");
  a_decode_hit: assert property (dec && instr_i[19:16] == 4'h0 |->
    branch_hit_o && !predict_taken_o) else $error("decode wrong");
  a_reserved_likely: assert property (dec && instr_i[19:16] == 4'h2 |->
    reserved_exc_o == early_level_i && predict_taken_o != early_level_i) else $error("likely");
  a_nullify_slot: assert property (slot_nullify_o |-> !redirect_o && busy_o)
    else $error("nullify wrong");
  a_redirect_slot: assert property (redirect_o |-> busy_o && instr_valid_i && !slot_exc_i)
    else $error("redirect wrong");
  a_busy_window: assert property (branch_hit_o |=> busy_o)
    else $error("busy missing");
  a_resume_pulse: assert property (busy_o && instr_valid_i && slot_exc_i &&
    !slot_nullify_o |=> resume_o ##1 !resume_o) else $error("resume wrong");
  a_squash_quiet: assert property (slot_nullify_o |=> !resume_o)
    else $error("nullified slot fault resumed");
endmodule : bnu_properties
bind bnu_branch_unit bnu_properties chk_u (.*);
`default_nettype wire

// ===== bench/bnu_branch_unit_tb.sv
// Self-checking bench for the branch unit
`timescale 1ns/10ps
`default_nettype none
module bnu_branch_unit_tb import bnu_pkg::*;;
  logic clk_i, reset_i, early_level_i, instr_valid_i, slot_exc_i, branch_hit_o, reserved_exc_o;
  logic predict_taken_o, slot_nullify_o, mispredict_o, redirect_o, link_we_o, resume_o, busy_o;
  logic [31:0] instr_i, instr_pc_i, src_data_i, target_o, link_data_o, resume_pc_o;
  logic [4:0] src_idx_o, link_idx_o;
  int miscompares, n_checks, cyc;
  bnu_branch_unit dut_u (.clk_i(clk_i), .reset_i(reset_i), .early_level_i(early_level_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_pc_i(instr_pc_i),
    .src_data_i(src_data_i), .slot_exc_i(slot_exc_i), .src_idx_o(src_idx_o),
    .branch_hit_o(branch_hit_o), .reserved_exc_o(reserved_exc_o),
    .predict_taken_o(predict_taken_o), .slot_nullify_o(slot_nullify_o),
    .mispredict_o(mispredict_o), .redirect_o(redirect_o), .target_o(target_o),
    .link_we_o(link_we_o), .link_idx_o(link_idx_o), .link_data_o(link_data_o),
    .resume_o(resume_o), .resume_pc_o(resume_pc_o), .busy_o(busy_o));
  bnu_regfile rf_u (.clk_i(clk_i), .rd_idx_i(src_idx_o), .rd_data_o(src_data_i),
    .we_i(link_we_o), .wr_idx_i(link_idx_o), .wr_data_i(link_data_o));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task run(input logic [4:0] sub, input logic [4:0] src, input logic [15:0] imm, input logic ex);
    logic li, ng, rsv, tr;
    li = sub[1];
    ng = rf_u.regs[src][31];
    rsv = li && early_level_i;
    // Slot fault counts only when the slot really runs
    tr = ex && !rsv && !(li && !ng);
    rf_u.regs[31] = 32'h0;
    @(posedge clk_i);
    #1 instr_valid_i = 1'b1;
    instr_i = {OPC_REG_IMM, src, sub, imm};
    instr_pc_i = 32'h0000_4000;
    #1 chk("hit", !rsv, branch_hit_o);
    chk("src", src, src_idx_o);
    chk("rsv", rsv, reserved_exc_o);
    chk("pred", li && !rsv, predict_taken_o);
    if (!rsv) begin
      @(posedge clk_i);
      #1 instr_i = 32'h0;
      instr_pc_i = 32'h0000_4004;
      slot_exc_i = ex;
      #1 chk("redir", ng && !ex, redirect_o);
      chk("null", li && !ng, slot_nullify_o);
      chk("misp", li && !ng, mispredict_o);
      chk("busy1", 1'b1, busy_o);
      chk("tgt", 32'h0000_4004 + {{14{imm[15]}}, imm, 2'b00}, target_o);
      chk("lwe", sub[4], link_we_o);
      chk("lidx", 32'h0000_001f, link_idx_o);
      if (sub[4]) chk("ldat", 32'h0000_4008, link_data_o);
    end
    @(posedge clk_i);
    #1 instr_valid_i = 1'b0;
    slot_exc_i = 1'b0;
    #1 chk("res", tr, resume_o);
    if (tr) chk("rpc", 32'h0000_4000, resume_pc_o);
    if (sub[4] && !rsv) chk("r31", 32'h0000_4008, rf_u.regs[31]);
    chk("busy", 1'b0, busy_o);
  endtask : run
  task t_forms;
    for (int r = 1; r < 4; r++) begin
      run(SUB_NEG, r[4:0], 16'h8000, 1'b0);
      run(SUB_NEG_LINK, r[4:0], 16'h7fff, 1'b0);
      run(SUB_NEG_LIKELY, r[4:0], 16'h7fff, 1'b0);
      run(SUB_NEG_LINK_LIKELY, r[4:0], 16'h8000, 1'b0);
    end
  endtask : t_forms
  task t_early;
    @(posedge clk_i);
    #1 early_level_i = 1'b1;
    run(SUB_NEG_LIKELY, 5'h01, 16'h0004, 1'b0);
    run(SUB_NEG_LINK_LIKELY, 5'h01, 16'h0004, 1'b0);
    run(SUB_NEG_LINK, 5'h01, 16'h0004, 1'b0);
    @(posedge clk_i);
    #1 early_level_i = 1'b0;
  endtask : t_early
  task t_slot_exc;
    run(SUB_NEG_LINK, 5'h01, 16'h0004, 1'b1);
    run(SUB_NEG, 5'h01, 16'hfffc, 1'b1);
    run(SUB_NEG_LIKELY, 5'h01, 16'h0004, 1'b1);
    run(SUB_NEG_LINK_LIKELY, 5'h02, 16'h0004, 1'b1);
  endtask : t_slot_exc
  task t_foreign;
    @(posedge clk_i);
    #1 instr_valid_i = 1'b1;
    instr_i = {OPC_REG_IMM, 5'h01, 5'h01, 16'h0004};
    #1 chk("fsub", 1'b0, branch_hit_o);
    chk("frsv", 1'b0, reserved_exc_o);
    @(posedge clk_i);
    #1 instr_i = {6'h04, 5'h01, SUB_NEG, 16'h0004};
    #1 chk("fopc", 1'b0, branch_hit_o);
    @(posedge clk_i);
    #1 instr_valid_i = 1'b0;
    #1 chk("fbusy", 1'b0, busy_o);
  endtask : t_foreign
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Whole run is under 200 cycles; the ceiling only catches a hang
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {reset_i, early_level_i, instr_valid_i, slot_exc_i} = 4'h8;
    instr_i = 32'h0;
    instr_pc_i = 32'h0;
    rf_u.regs[0] = 32'h0;
    rf_u.regs[1] = 32'h8000_0000;
    rf_u.regs[2] = 32'h7fff_ffff;
    rf_u.regs[3] = 32'h0;
    repeat (8) @(posedge clk_i);
    #1 reset_i = 1'b0;
    t_forms();
    t_early();
    t_slot_exc();
    t_foreign();
    conclude();
  end
endmodule : bnu_branch_unit_tb
`default_nettype wire
